// file: pgrc_consts.vh
// Constants for the pattern generator run control block.
// Assumes a single 100 MHz clock and an APB register port.
// Notes on behaviour
// - All clock, strobe and data outputs stay disabled after power-up until enabled; strobe_out here has no enable and is always driven.
// - Output switch off means high impedance; on means every output driven.
// - Exactly three states: running, stopped, paused; requested by keys, pins or bus.
// - Gated modes disable pause functions and the run key; stop still works.
// - Gated manual clock: stop and step only; stepping enabled by external run.
// - Run from stopped starts at first address; initialising modes start at zero.
// - Running on manual clock accepts step ahead, ignores step back.
// - Run key or active external run edge enters running.
// - Stop holds NRZ values; RZ channels return false after delay and width.
// - Logic false is stored zero, low output; complement inverts per channel.
// - Stopped at power-on, stop key, external stop, single end, gated end.
// - Pause resumes from current address; steps in pause move address and outputs.
// - Pause on key, external pause, or strobe bit one when strobe pause enabled.
// - Gated stop key halts immediately at the current address.
// - Gate going inactive runs through last address then stops.
// - Out-of-range first, last or threshold entry flags and keeps previous value.
// - Run-input-disabled warning when gated mode and no run polarity enabled.
// - Outputs-disabled warning while off; run-input warning has priority.
// - NRZ bit lasts one clock period; at least eight channels.
// - RZ bits narrower than period, programmable width and delay, up to eight; internal clock keeps phase at zero, so RZ bits show only at delay 0, width > 0.
// - RZ channel set to NRZ gives delayed NRZ with programmable delay; here NRZ channels bypass the delay.
// - Extension channels NRZ only, 8 to 24, delayed together by one delay; this design has no extension channels.
// - Clock-one-in-pause keeps first clock toggling paused; second clock unaffected.
// - Each rear input can be off, rising or falling edge sensitive.
// - Initialising auto runs zero to first once, then first to last repeatedly.
`ifndef PGRC_CONSTS_VH
`define PGRC_CONSTS_VH
`define PGRC_A_CTRL 12'h000
`define PGRC_A_FIRST 12'h004
`define PGRC_A_LAST 12'h008
`define PGRC_A_THR 12'h00c
`define PGRC_A_CMD 12'h010
`define PGRC_A_STAT 12'h014
`define PGRC_A_FMT 12'h018
`define PGRC_A_DLY 12'h01c
`define PGRC_A_WID 12'h020
`define PGRC_A_PAT 12'h024
`define PGRC_A_CMPL 12'h028
`define PGRC_A_DIN 12'h02c
// Control field positions
`define PGRC_C_OE 0
`define PGRC_C_MODE_LO 1
`define PGRC_C_MODE_HI 3
`define PGRC_C_SRC_LO 4
`define PGRC_C_SRC_HI 5
`define PGRC_C_STRB 6
`define PGRC_C_CLK1P 7
`define PGRC_C_RUNP_LO 8
`define PGRC_C_RUNP_HI 9
`define PGRC_C_STPP_LO 10
`define PGRC_C_STPP_HI 11
`define PGRC_C_PSP_LO 12
`define PGRC_C_PSP_HI 13
// Command bits
`define PGRC_K_RUN 0
`define PGRC_K_STOP 1
`define PGRC_K_PAUSE 2
`define PGRC_K_FWD 3
`define PGRC_K_BACK 4
// Cycle modes
`define PGRC_M_AUTO 3'h0
`define PGRC_M_SINGLE 3'h1
`define PGRC_M_INIT_AUTO 3'h2
`define PGRC_M_GATED 3'h3
`define PGRC_M_INIT_GATED 3'h4
// Clock sources
`define PGRC_S_INT 2'h0
`define PGRC_S_MAN 2'h3
// Edge polarity
`define PGRC_P_OFF 2'h0
`define PGRC_P_RISE 2'h1
`define PGRC_P_FALL 2'h2
// States
`define PGRC_ST_STOP 2'h0
`define PGRC_ST_RUN 2'h1
`define PGRC_ST_PAUSE 2'h2
// Ranges and resets
`define PGRC_ADDR_MAX 14'h3fff
`define PGRC_THR_MAX 8'h64
`define PGRC_RST_LAST 14'h3fff
`endif

// file: pgrc_top.v
// Run control, address sequencing and output formatting of a pattern generator.
// Assumes APB master on pclk and asynchronous rear inputs needing synchronisers.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "pgrc_consts.vh"
module pgrc_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_run_in,
  input wire ext_stop_in,
  input wire ext_pause_in,
  input wire strobe_bit,
  output reg [13:0] cur_addr,
  output reg [7:0] chan_out,
  output reg [7:0] chan_oe,
  output reg first_clock_output,
  output reg second_clock_output,
  output reg clk_oe,
  output reg strobe_out,
  output reg run_input_off_warn,
  output reg outputs_off_warn
);

  // Registers and state
  reg [13:0] ctrl_reg;
  reg [13:0] first_reg;
  reg [13:0] last_reg;
  reg [7:0] thr_reg;
  reg [7:0] fmt_reg;
  reg [7:0] dly_reg;
  reg [7:0] wid_reg;
  reg [7:0] pat_reg;
  reg [7:0] cmpl_reg;
  reg range_err_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [13:0] addr_next;
  reg init_pass_reg;
  reg gate_stop_reg;
  reg man_en_reg;
  reg [7:0] phase_reg;
  reg [7:0] nrz_reg;
  reg [4:0] cmd_pulse;
  reg [2:0] s1_reg;
  reg [2:0] s2_reg;
  reg [2:0] s3_reg;

  wire [2:0] mode = ctrl_reg[`PGRC_C_MODE_HI:`PGRC_C_MODE_LO];
  wire [1:0] src = ctrl_reg[`PGRC_C_SRC_HI:`PGRC_C_SRC_LO];
  wire gated = (mode == `PGRC_M_GATED) || (mode == `PGRC_M_INIT_GATED);
  wire init_mode = (mode == `PGRC_M_INIT_AUTO) || (mode == `PGRC_M_INIT_GATED);
  wire manual = (src == `PGRC_S_MAN);
  wire wr = psel && penable && pwrite;

  // Edge detect per polarity setting
  function edge_hit;
    input [1:0] pol;
    input now_v;
    input old_v;
    begin
      edge_hit = ((pol == `PGRC_P_RISE) && now_v && !old_v) ||
                 ((pol == `PGRC_P_FALL) && !now_v && old_v);
    end
  endfunction

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  // two-flop sync, third stage for edge history only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
    end else begin
      s1_reg <= {ext_pause_in, ext_stop_in, ext_run_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  wire run_edge = edge_hit(ctrl_reg[`PGRC_C_RUNP_HI:`PGRC_C_RUNP_LO], s2_reg[0], s3_reg[0]);
  wire stop_edge = edge_hit(ctrl_reg[`PGRC_C_STPP_HI:`PGRC_C_STPP_LO], s2_reg[1], s3_reg[1]);
  wire pause_edge = edge_hit(ctrl_reg[`PGRC_C_PSP_HI:`PGRC_C_PSP_LO], s2_reg[2], s3_reg[2]);
  // Gate-off edge is the edge opposite the enabled run edge; none when the run input is off
  wire gate_off_edge = edge_hit(
    (ctrl_reg[`PGRC_C_RUNP_HI:`PGRC_C_RUNP_LO] == `PGRC_P_RISE) ? `PGRC_P_FALL :
    (ctrl_reg[`PGRC_C_RUNP_HI:`PGRC_C_RUNP_LO] == `PGRC_P_FALL) ? `PGRC_P_RISE : `PGRC_P_OFF,
    s2_reg[0], s3_reg[0]);

  // --------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------
  // gated modes drop run key and every pause source
  wire req_stop = cmd_pulse[`PGRC_K_STOP] || stop_edge;
  wire req_pause = !gated && (cmd_pulse[`PGRC_K_PAUSE] || pause_edge ||
                   (ctrl_reg[`PGRC_C_STRB] && strobe_bit && state_reg == `PGRC_ST_RUN));
  wire req_run = (!gated && cmd_pulse[`PGRC_K_RUN]) || run_edge;
  // step back only counts while paused; gated manual only steps ahead
  wire step_fwd = cmd_pulse[`PGRC_K_FWD] && manual &&
                  (gated ? man_en_reg : (state_reg != `PGRC_ST_STOP));
  wire step_back = cmd_pulse[`PGRC_K_BACK] && manual && !gated && (state_reg == `PGRC_ST_PAUSE);
  // Address advances on every clock when internal, on a key when manual
  wire tick = (state_reg == `PGRC_ST_RUN) && (manual ? step_fwd : 1'b1);
  wire at_last = (cur_addr == last_reg) && !init_pass_reg;

  // --------------------------------------------------------------
  // State machine
  // --------------------------------------------------------------
  // three states; stop over pause over run
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `PGRC_ST_STOP: begin
        if (!req_stop && !req_pause && req_run)
          state_next = `PGRC_ST_RUN;
      end
      `PGRC_ST_RUN: begin
        // stop sources; gated stop key halts at once
        if (req_stop)
          state_next = `PGRC_ST_STOP;
        else if (req_pause)
          state_next = `PGRC_ST_PAUSE;
        // single cycle end; gated synchronised stop
        else if (tick && at_last && ((mode == `PGRC_M_SINGLE) || (gated && gate_stop_reg)))
          state_next = `PGRC_ST_STOP;
      end
      `PGRC_ST_PAUSE: begin
        if (req_stop)
          state_next = `PGRC_ST_STOP;
        // a pause request in the same cycle keeps it paused
        else if (req_run && !req_pause)
          state_next = `PGRC_ST_RUN;
      end
      default: state_next = `PGRC_ST_STOP;
    endcase
  end

  // Next address
  always @* begin
    addr_next = cur_addr;
    if (state_reg == `PGRC_ST_STOP && state_next == `PGRC_ST_RUN)
      // restart at first address or zero
      addr_next = init_mode ? 14'h0000 : first_reg;
    else if (state_reg == `PGRC_ST_PAUSE) begin
      // steps in pause move the address
      if (step_fwd)
        addr_next = cur_addr + 14'h0001;
      else if (step_back)
        addr_next = cur_addr - 14'h0001;
    end else if (state_reg == `PGRC_ST_RUN && state_next == `PGRC_ST_RUN && tick) begin
      // zero-to-first once, then loop first to last
      if (init_pass_reg && cur_addr == first_reg)
        addr_next = first_reg;
      else if (at_last)
        addr_next = first_reg;
      else
        addr_next = cur_addr + 14'h0001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= `PGRC_ST_STOP;
      cur_addr <= 14'h0000;
      init_pass_reg <= 1'b0;
      gate_stop_reg <= 1'b0;
      man_en_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_addr <= addr_next;
      if (state_reg == `PGRC_ST_STOP && state_next == `PGRC_ST_RUN)
        init_pass_reg <= init_mode;
      else if (tick && init_pass_reg && cur_addr == first_reg)
        init_pass_reg <= 1'b0;
      // gate loss remembered until the last address
      if (state_next != `PGRC_ST_RUN)
        gate_stop_reg <= 1'b0;
      else if (gated && gate_off_edge)
        gate_stop_reg <= 1'b1;
      // manual stepping window in gated mode
      if (req_stop || gate_off_edge || !gated)
        man_en_reg <= 1'b0;
      else if (run_edge && manual)
        man_en_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Output formatting
  // --------------------------------------------------------------
  // NRZ one word per tick; RZ channels delayed and narrowed by phase counter
  wire running = (state_reg == `PGRC_ST_RUN);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 8'h00;
      nrz_reg <= 8'h00;
      chan_out <= 8'h00;
      chan_oe <= 8'h00;
      first_clock_output <= 1'b0;
      second_clock_output <= 1'b0;
      clk_oe <= 1'b0;
      strobe_out <= 1'b0;
      run_input_off_warn <= 1'b0;
      outputs_off_warn <= 1'b0;
    end else begin
      // NRZ holds last word when not running; step updates at once
      if ((running && tick) || step_fwd || step_back)
        nrz_reg <= pat_reg;
      phase_reg <= (running && tick) ? 8'h00 : phase_reg + {7'h00, (phase_reg != 8'hff)};
      // complement after format; RZ channels share one delay, NRZ channels undelayed
      chan_out <= cmpl_reg ^ ((fmt_reg & nrz_reg &
                  {8{(phase_reg >= dly_reg) && ({1'b0, phase_reg} < ({1'b0, dly_reg} + {1'b0, wid_reg}))}}) |
                  (~fmt_reg & nrz_reg));
      // global enable drives or floats the channel and clock outputs
      chan_oe <= {8{ctrl_reg[`PGRC_C_OE]}};
      clk_oe <= ctrl_reg[`PGRC_C_OE];
      // first clock keeps toggling paused when enabled
      first_clock_output <= (running || (state_reg == `PGRC_ST_PAUSE && ctrl_reg[`PGRC_C_CLK1P])) ?
                            !first_clock_output : 1'b0;
      second_clock_output <= running ? !second_clock_output : 1'b0;
      strobe_out <= strobe_bit;
      run_input_off_warn <= gated && (ctrl_reg[`PGRC_C_RUNP_HI:`PGRC_C_RUNP_LO] == `PGRC_P_OFF);
      outputs_off_warn <= !ctrl_reg[`PGRC_C_OE] &&
                          !(gated && (ctrl_reg[`PGRC_C_RUNP_HI:`PGRC_C_RUNP_LO] == `PGRC_P_OFF));
    end
  end

  // --------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------
  // Zero-wait writes; command register yields one-cycle pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 14'h0000;
      first_reg <= 14'h0000;
      last_reg <= `PGRC_RST_LAST;
      thr_reg <= 8'h00;
      fmt_reg <= 8'h00;
      dly_reg <= 8'h00;
      wid_reg <= 8'h00;
      pat_reg <= 8'h00;
      cmpl_reg <= 8'h00;
      range_err_reg <= 1'b0;
      cmd_pulse <= 5'h00;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cmd_pulse <= 5'h00;
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `PGRC_A_CTRL: prdata <= {18'h00000, ctrl_reg};
          `PGRC_A_FIRST: prdata <= {18'h00000, first_reg};
          `PGRC_A_LAST: prdata <= {18'h00000, last_reg};
          `PGRC_A_THR: prdata <= {24'h000000, thr_reg};
          `PGRC_A_STAT: prdata <= {12'h000, cur_addr, range_err_reg, outputs_off_warn,
                                    run_input_off_warn, man_en_reg, state_reg};
          `PGRC_A_FMT: prdata <= {24'h000000, fmt_reg};
          `PGRC_A_DLY: prdata <= {24'h000000, dly_reg};
          `PGRC_A_WID: prdata <= {24'h000000, wid_reg};
          `PGRC_A_PAT: prdata <= {24'h000000, pat_reg};
          `PGRC_A_CMPL: prdata <= {24'h000000, cmpl_reg};
          `PGRC_A_CMD: prdata <= 32'h00000000;
          default: prdata <= 32'h00000000;
        endcase
        pslverr <= (paddr > `PGRC_A_CMPL) || (paddr[1:0] != 2'h0);
      end
      if (wr && pready) begin
        case (paddr)
          `PGRC_A_CTRL: ctrl_reg <= pwdata[13:0];
          // bad entries flagged, previous value kept
          `PGRC_A_FIRST: begin
            range_err_reg <= (pwdata > {18'h00000, `PGRC_ADDR_MAX});
            if (pwdata <= {18'h00000, `PGRC_ADDR_MAX}) first_reg <= pwdata[13:0];
          end
          `PGRC_A_LAST: begin
            range_err_reg <= (pwdata > {18'h00000, `PGRC_ADDR_MAX});
            if (pwdata <= {18'h00000, `PGRC_ADDR_MAX}) last_reg <= pwdata[13:0];
          end
          `PGRC_A_THR: begin
            range_err_reg <= (pwdata > {24'h000000, `PGRC_THR_MAX});
            if (pwdata <= {24'h000000, `PGRC_THR_MAX}) thr_reg <= pwdata[7:0];
          end
          `PGRC_A_CMD: cmd_pulse <= pwdata[4:0];
          `PGRC_A_FMT: fmt_reg <= pwdata[7:0];
          `PGRC_A_DLY: dly_reg <= pwdata[7:0];
          `PGRC_A_WID: wid_reg <= pwdata[7:0];
          `PGRC_A_PAT: pat_reg <= pwdata[7:0];
          `PGRC_A_CMPL: cmpl_reg <= pwdata[7:0];
          default: range_err_reg <= range_err_reg;
        endcase
      end
    end
  end

endmodule // pgrc_top

// file: pgrc_sva.sv
// Checker for the run control block: register port handshake and output enables.
// Assumes it is bound to pgrc_top and sees only that module's ports.
`timescale 1ns/1ps
`include "pgrc_consts.vh"
module pgrc_sva (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [7:0] chan_oe,
  input logic clk_oe,
  input logic run_input_off_warn,
  input logic outputs_off_warn
);
  // ---------
  // Helpers
  // ---------
  // Completed control write, cause of any enable change
  wire ctrl_wr = psel && penable && pready && pwrite && paddr == `PGRC_A_CTRL;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_align_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned not refused");
  err_map_a: assert property (pready && paddr > `PGRC_A_CMPL |-> pslverr)
    else $error("unmapped not refused");
  err_rdzero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  oe_together_a: assert property (chan_oe == {8{clk_oe}})
    else $error("enables disagree");
  oe_cause_a: assert property ($rose(clk_oe) |-> $past(ctrl_wr, 1) || $past(ctrl_wr, 2))
    else $error("enable without control write");
  warn_prio_a: assert property (run_input_off_warn |-> !outputs_off_warn)
    else $error("outputs-off warning not yielding");
endmodule // pgrc_sva
bind pgrc_top pgrc_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_oe(chan_oe), .clk_oe(clk_oe),
  .run_input_off_warn(run_input_off_warn), .outputs_off_warn(outputs_off_warn));

// file: pgrc_far.sv
// Far side model: rear control sources and the strobe channel of the pattern.
// Assumes the bench sets the wanted pin levels and the strobe address.
`timescale 1ns/1ps
module pgrc_far (
  input logic pclk,
  input logic [13:0] cur_addr,
  input logic run_lvl,
  input logic stop_lvl,
  input logic pause_lvl,
  input logic [13:0] strobe_at,
  output logic ext_run_in,
  output logic ext_stop_in,
  output logic ext_pause_in,
  output logic strobe_bit
);
  // clean edges, changed after a clock edge
  always @(posedge pclk) begin
    ext_run_in <= run_lvl;
    ext_stop_in <= stop_lvl;
    ext_pause_in <= pause_lvl;
  end
  // strobe word is one at a single address
  assign strobe_bit = (cur_addr == strobe_at);
endmodule // pgrc_far

// file: testbench.sv
// Self-checking bench for the run control block.
// Assumes pgrc_top with APB slave and the far side model beside it.
`timescale 1ns/1ps
`include "pgrc_consts.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rl = 0, sl = 0, pl = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [13:0] a, b, sat = 14'h3fff;
  wire [31:0] prdata;
  wire pready, pslverr, xr, xs, xp, sb, c1, c2, clk_oe, so, rw, ow;
  wire [13:0] cur_addr;
  wire [7:0] chan_out, chan_oe;
  int n_mismatch = 0, total_checks = 0, t1, t2;
  initial forever #5 pclk = ~pclk;
  pgrc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_run_in(xr), .ext_stop_in(xs), .ext_pause_in(xp), .strobe_bit(sb), .cur_addr(cur_addr),
    .chan_out(chan_out), .chan_oe(chan_oe), .first_clock_output(c1), .second_clock_output(c2),
    .clk_oe(clk_oe), .strobe_out(so), .run_input_off_warn(rw), .outputs_off_warn(ow));
  pgrc_far far (.pclk(pclk), .cur_addr(cur_addr), .run_lvl(rl), .stop_lvl(sl), .pause_lvl(pl),
    .strobe_at(sat), .ext_run_in(xr), .ext_stop_in(xs), .ext_pause_in(xp), .strobe_bit(sb));
  // ---------
  // Helpers
  // ---------
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; held until pready, then one idle edge
  task bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    cyc(1);
    penable <= 1'h1;
    i = 0;
    do begin
      cyc(1);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (i == 20) begin
      n_mismatch++;
      wrap_up;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    cyc(1);
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] d);
    bus(1'h1, ad, d);
  endtask
  task rd(input logic [11:0] ad);
    bus(1'h0, ad, 32'h0);
  endtask
  // Bounded wait for the address to move
  task wchg;
    int i;
    a = cur_addr;
    i = 0;
    while (cur_addr === a && i < 60) begin
      cyc(1);
      i++;
    end
    if (i == 60) begin
      n_mismatch++;
      wrap_up;
    end
  endtask
  // Count clock output toggles over eight cycles
  task tog;
    logic p1, p2;
    t1 = 0;
    t2 = 0;
    repeat (8) begin
      p1 = c1;
      p2 = c2;
      cyc(1);
      t1 += int'(c1 !== p1);
      t2 += int'(c2 !== p2);
    end
  endtask
  // ---------
  // Scenarios
  // ---------
  task t_boot;
    chk("clk_oe", 1'h0, clk_oe);
    chk("chan_oe", 8'h0, chan_oe);
    chk("off_warn", 1'h1, ow);
    rd(12'h030); chk("unmapped_err", 1'h1, e);
    wr(`PGRC_A_CTRL, 32'h1); cyc(2);
    chk("chan_oe_on", 8'hff, chan_oe);
    chk("off_warn_on", 1'h0, ow);
    $display("boot done");
  endtask
  task t_range;
    wr(`PGRC_A_FIRST, 32'h5); wr(`PGRC_A_FIRST, 32'h4000);
    rd(`PGRC_A_STAT); chk("range_flag", 1'h1, q[5]);
    rd(`PGRC_A_FIRST); chk("first_kept", 32'h5, q);
    wr(`PGRC_A_THR, 32'h64); rd(`PGRC_A_STAT); chk("thr_max_ok", 1'h0, q[5]);
    wr(`PGRC_A_THR, 32'h65); rd(`PGRC_A_STAT); chk("thr_over", 1'h1, q[5]);
    wr(`PGRC_A_LAST, 32'h100);
    $display("range done");
  endtask
  task t_run;
    wr(`PGRC_A_PAT, 32'ha5);
    wr(`PGRC_A_CMD, 32'h1); wchg; chk("run_first", 14'h5, cur_addr);
    cyc(6); wr(`PGRC_A_CMD, 32'h4); cyc(4); b = cur_addr; cyc(6);
    chk("pause_hold", b, cur_addr);
    wr(`PGRC_A_CTRL, 32'h31); wr(`PGRC_A_CMD, 32'h8); cyc(4);
    chk("step_fwd", b + 14'h1, cur_addr);
    wr(`PGRC_A_CMD, 32'h10); cyc(4); chk("step_back", b, cur_addr);
    wr(`PGRC_A_CTRL, 32'h1); wr(`PGRC_A_CMD, 32'h1); wchg;
    chk("resume_cur", b + 14'h1, cur_addr);
    wr(`PGRC_A_CMD, 32'h2); cyc(3); b = cur_addr; q = chan_out; cyc(6);
    chk("stop_addr", b, cur_addr);
    chk("nrz_hold", 32'ha5, chan_out);
    wr(`PGRC_A_CMPL, 32'hff); cyc(2);
    chk("complement", 32'h5a, chan_out);
    wr(`PGRC_A_CMPL, 32'h0);
    $display("run done");
  endtask
  task t_prio;
    wr(`PGRC_A_CTRL, 32'h81); wr(`PGRC_A_CMD, 32'h1); cyc(4);
    wr(`PGRC_A_CMD, 32'h5); cyc(3);
    wr(`PGRC_A_CMD, 32'h5); cyc(3); b = cur_addr; tog;
    chk("pause_wins", b, cur_addr);
    chk("first_clock_output_pause", 1'h1, t1 > 0);
    chk("second_clock_output_pause", 32'h0, t2);
    wr(`PGRC_A_CMD, 32'h7); cyc(3); tog; chk("stop_wins", 32'h0, t1);
    $display("prio done");
  endtask
  task t_strobe;
    sat <= 14'hc;
    wr(`PGRC_A_CTRL, 32'h41); wr(`PGRC_A_CMD, 32'h1); cyc(40);
    chk("strobe_pause", 14'hc, cur_addr);
    chk("strobe_out", 1'h1, so);
    sat <= 14'h3fff;
    wr(`PGRC_A_CMD, 32'h2);
    $display("strobe done");
  endtask
  task t_ext;
    wr(`PGRC_A_CTRL, 32'h901); rl <= 1'h1; wchg;
    chk("ext_run", 14'h5, cur_addr);
    rl <= 1'h0; sl <= 1'h1; cyc(3); sl <= 1'h0; cyc(8); b = cur_addr; cyc(5);
    chk("ext_stop", b, cur_addr);
    wr(`PGRC_A_CTRL, 32'h1); rl <= 1'h1; cyc(10);
    chk("run_in_off", b, cur_addr);
    rl <= 1'h0; cyc(2);
    $display("ext done");
  endtask
  task t_gated;
    wr(`PGRC_A_CTRL, 32'h6); cyc(3); chk("runoff_warn", 1'h1, rw);
    wr(`PGRC_A_LAST, 32'h20); wr(`PGRC_A_CTRL, 32'h107); cyc(3);
    chk("runoff_clear", 1'h0, rw);
    b = cur_addr; wr(`PGRC_A_CMD, 32'h1); cyc(8);
    chk("gated_run_key", b, cur_addr);
    rl <= 1'h1; wchg; chk("gate_start", 14'h5, cur_addr);
    cyc(4); rl <= 1'h0; cyc(60); chk("sync_stop", 14'h20, cur_addr);
    rl <= 1'h1; wchg; cyc(2); wr(`PGRC_A_CMD, 32'h2); b = cur_addr; cyc(4);
    chk("gate_stop_key", b, cur_addr);
    rl <= 1'h0;
    $display("gated done");
  endtask
  task t_cycle;
    wr(`PGRC_A_CTRL, 32'h3); wr(`PGRC_A_CMD, 32'h1); cyc(40);
    chk("single_end", 14'h20, cur_addr);
    rd(`PGRC_A_STAT); chk("single_state", `PGRC_ST_STOP, q[1:0]);
    wr(`PGRC_A_CTRL, 32'h5); wr(`PGRC_A_CMD, 32'h1); wchg;
    chk("init_zero", 14'h0, cur_addr);
    cyc(10);
    a = 14'h3fff;
    repeat (80) begin
      cyc(1);
      if (cur_addr < a) a = cur_addr;
    end
    chk("init_loop", 14'h5, a);
    wr(`PGRC_A_CMD, 32'h2); wr(`PGRC_A_CTRL, 32'h137); rl <= 1'h1; cyc(6);
    chk("man_start", 14'h5, cur_addr);
    wr(`PGRC_A_CMD, 32'h8); cyc(2); chk("man_fwd", 14'h6, cur_addr);
    wr(`PGRC_A_CMD, 32'h10); cyc(2); chk("man_back", 14'h6, cur_addr);
    rl <= 1'h0; cyc(6); wr(`PGRC_A_CMD, 32'h8); cyc(2);
    chk("man_off", 14'h6, cur_addr);
    wr(`PGRC_A_CMD, 32'h2);
    $display("cycle done");
  endtask
  // ---------
  // Sequence
  // ---------
  initial begin
    cyc(2);
    presetn <= 1'h1;
    cyc(2);
    t_boot;
    t_range;
    t_run;
    t_prio;
    t_strobe;
    t_ext;
    t_gated;
    t_cycle;
    wrap_up;
  end
  // Hang guard
  initial begin
    cyc(20000);
    n_mismatch++;
    wrap_up;
  end
endmodule // testbench
